/* logic/lbc_map.vh */
// Constants for the light-bar control input logic
`ifndef LBC_MAP_VH
`define LBC_MAP_VH
// Register byte offsets
`define LBC_OFS_CTRL 8'h00
`define LBC_OFS_PAT1 8'h04
`define LBC_OFS_PAT2 8'h08
`define LBC_OFS_PAT3 8'h0C
`define LBC_OFS_PATI 8'h10
`define LBC_OFS_STAT 8'h14
// Control register fields and reset values
`define LBC_CTRL_CUTPOL_BIT 0
`define LBC_CTRL_RST 1'b0
`define LBC_PAT_RST 4'h0
// Status register field positions
`define LBC_STAT_MODE_LSB 0
`define LBC_STAT_ISEC_BIT 2
`define LBC_STAT_LP_BIT 3
`define LBC_STAT_PROG_BIT 4
`define LBC_STAT_DWINT_BIT 5
`define LBC_STAT_CUTPOL_BIT 6
// Configuration switch positions (switch n sits at bit n-1)
`define LBC_SW_SCENE 2
`define LBC_SW_DWINT 3
`define LBC_SW_STEPDIR 4
`define LBC_SW_PROG 5
`define LBC_SW_ISEC_A 6
`define LBC_SW_ISEC_B 7
// Timing
`define LBC_CLK_HZ 20000000
`define LBC_DEB_US 5000
// Debounce count: LBC_DEB_US at LBC_CLK_HZ, sized for the 20-bit counter
`define LBC_DEB_CYC 20'h186A0
`define LBC_ISEC_S 8
// Timeout count: LBC_ISEC_S at LBC_CLK_HZ, sized for the 28-bit counter
`define LBC_ISEC_CYC 28'h9896800
`define LBC_CAP_WAIT 2'h3
`endif

/* logic/lbc_input_logic.v */
// Light-bar control input decision logic with register port
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "lbc_map.vh"
module lbc_input_logic #(
    parameter [19:0] DEB_CYC = `LBC_DEB_CYC,
    parameter [27:0] ISEC_CYC = `LBC_ISEC_CYC
) (
    input wire core_clk_i,
    input wire reset_i,
    input wire clk_en_i,
    input wire mode1_i,
    input wire mode2_i,
    input wire mode3_i,
    input wire steady_i,
    input wire isec_i,
    input wire flash_td_i,
    input wire alley_l_i,
    input wire alley_r_i,
    input wire takedown_i,
    input wire front_cut_i,
    input wire rear_cut_i,
    input wire low_power_i,
    input wire test_i,
    input wire [7:0] dw_ext_i,
    input wire [7:0] config_switch_bank_i,
    input wire pattern_step_button_i,
    input wire [7:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    output reg [1:0] mode_o,
    output reg [3:0] pattern_o,
    output reg isec_o,
    output reg front_en_o,
    output reg rear_en_o,
    output reg steady_o,
    output reg alley_l_o,
    output reg alley_r_o,
    output reg alley_flash_o,
    output reg td_flash_o,
    output reg td_steady_o,
    output reg low_power_o,
    output reg autodim_ovr_o,
    output reg scene_l_o,
    output reg scene_r_o,
    output reg test_o,
    output reg dw_internal_o,
    output reg [7:0] dw_ext_o,
    output reg program_o
);
    localparam NIN = 15; // Debounced control leads
    // Intersection behaviour codes from switches seven/eight
    localparam [1:0] ISB_LEVEL = 2'h0;
    localparam [1:0] ISB_TOGGLE = 2'h1;
    localparam [1:0] ISB_TIMED = 2'h2;

    // Mode arbitration, used for both output and change detection
    function [1:0] arb_mode;
        input m1;
        input m2;
        input m3;
        begin
            if (m3) begin
                arb_mode = 2'h3;
            end else if (m2) begin
                arb_mode = 2'h2;
            end else if (m1) begin
                arb_mode = 2'h1;
            end else begin
                arb_mode = 2'h0;
            end
        end
    endfunction

    // Raw lead vector, bit order fixed below
    wire [NIN-1:0] raw_in;
    assign raw_in = {pattern_step_button_i, test_i, low_power_i,
        rear_cut_i, front_cut_i, takedown_i, alley_r_i, alley_l_i,
        flash_td_i, isec_i, steady_i, mode3_i, mode2_i, mode1_i, 1'b0};
    wire [NIN-1:0] deb; // Clean levels, high means asserted except cutoffs when cutpol_reg is 1
    reg [7:0] sw_s1_reg; // Switch sync stages
    reg [7:0] sw_s2_reg;
    reg [7:0] dw_s1_reg; // Head sync stages
    reg [7:0] dw_s2_reg;

    // Per-lead sync and debounce; bounce would double-step toggles
    genvar g;
    generate
        for (g = 0; g < NIN; g = g + 1) begin : g_in
            reg s1_reg;
            reg s2_reg;
            reg lvl_reg;
            reg [19:0] cnt_reg;
            always @(posedge core_clk_i) begin
                if (reset_i) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    lvl_reg <= 1'b0;
                    cnt_reg <= 20'h00000;
                end else if (clk_en_i) begin
                    s1_reg <= raw_in[g];
                    s2_reg <= s1_reg;
                    // Accept a new level only after it stays put
                    if (s2_reg == lvl_reg) begin
                        cnt_reg <= 20'h00000;
                    end else if (cnt_reg >= DEB_CYC - 20'h00001) begin
                        lvl_reg <= s2_reg;
                        cnt_reg <= 20'h00000;
                    end else begin
                        cnt_reg <= cnt_reg + 20'h00001;
                    end
                end
            end
            assign deb[g] = lvl_reg;
        end
    endgenerate

    // Named clean levels
    wire m1 = deb[1];
    wire m2 = deb[2];
    wire m3 = deb[3];
    wire steady_l = deb[4];
    wire isec_l = deb[5];
    wire ftd_l = deb[6];
    wire al_l = deb[7];
    wire ar_l = deb[8];
    wire td_l = deb[9];
    wire fc_l = deb[10];
    wire rc_l = deb[11];
    wire lp_l = deb[12];
    wire test_l = deb[13];
    wire btn_l = deb[14];

    reg [NIN-1:0] deb_d_reg; // Previous clean levels for edges
    reg [1:0] cap_cnt_reg; // Power-up wait before switch capture
    reg cap_done_reg;
    reg [7:0] sw_reg; // Switches as seen at power-up
    reg cutpol_reg; // Shared cutoff polarity, 1 = low active
    reg [3:0] pat_reg [0:3]; // Index 0 intersection, 1..3 modes
    reg isec_tog_reg; // Toggle behaviour state
    reg isec_tmr_reg; // Timed behaviour running
    reg [27:0] isec_cnt_reg; // Timed behaviour count
    reg [2:0] state_d_reg; // Previous {mode, intersection}
    reg lp_block_reg; // Low power held off since mode change

    // Edges of clean levels
    wire [NIN-1:0] rise = deb & ~deb_d_reg;
    wire [NIN-1:0] fall = ~deb & deb_d_reg;

    // Decoded power-up configuration
    wire scene = sw_reg[`LBC_SW_SCENE];
    wire dw_int = sw_reg[`LBC_SW_DWINT];
    wire step_back = sw_reg[`LBC_SW_STEPDIR];
    wire prog = sw_reg[`LBC_SW_PROG];
    wire [1:0] isb = {sw_reg[`LBC_SW_ISEC_B], sw_reg[`LBC_SW_ISEC_A]};

    // Combinational decisions
    wire [1:0] mode = arb_mode(m1, m2, m3);
    wire mode_on = (mode != 2'h0);
    wire isec_in = isec_l & ~scene;
    reg isec_raw;
    always @* begin
        // Behaviour select; both-on is unlisted, treated as level
        case (isb)
            ISB_LEVEL: isec_raw = isec_in;
            ISB_TOGGLE: isec_raw = isec_tog_reg;
            ISB_TIMED: isec_raw = isec_tmr_reg;
            default: isec_raw = isec_in;
        endcase
    end
    wire isec_act = isec_raw & mode_on;
    // Shared polarity for both cutoffs
    wire cut_f = cutpol_reg ? ~fc_l : fc_l;
    wire cut_r = cutpol_reg ? ~rc_l : rc_l;
    wire ftd_act = ftd_l & mode_on;
    wire [2:0] state_now = {mode, isec_act};
    wire mode_chg = (state_now != state_d_reg);
    wire lp_ok = (mode == 2'h1 || mode == 2'h2) & ~isec_act;
    wire [1:0] sel = isec_act ? 2'h0 : mode;
    wire do_step = prog & rise[14] & mode_on;

    // Power-up switch capture and edge history
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            cap_cnt_reg <= 2'h0;
            cap_done_reg <= 1'b0;
            sw_reg <= 8'h00;
            sw_s1_reg <= 8'h00;
            sw_s2_reg <= 8'h00;
            dw_s1_reg <= 8'h00;
            dw_s2_reg <= 8'h00;
            deb_d_reg <= {NIN{1'b0}};
        end else if (clk_en_i) begin
            sw_s1_reg <= config_switch_bank_i;
            sw_s2_reg <= sw_s1_reg;
            dw_s1_reg <= dw_ext_i;
            dw_s2_reg <= dw_s1_reg;
            deb_d_reg <= deb;
            // Switches are frozen after this; moving them needs a reset_i pulse
            if (!cap_done_reg) begin
                if (cap_cnt_reg == `LBC_CAP_WAIT) begin
                    sw_reg <= sw_s2_reg;
                    cap_done_reg <= 1'b1;
                end else begin
                    cap_cnt_reg <= cap_cnt_reg + 2'h1;
                end
            end
        end
    end

    // Intersection toggle and timer
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            isec_tog_reg <= 1'b0;
            isec_tmr_reg <= 1'b0;
            isec_cnt_reg <= 28'h0000000;
        end else if (clk_en_i) begin
            // Toggle state dropped with the mode so it restarts off
            if (!mode_on) begin
                isec_tog_reg <= 1'b0;
            end else if (rise[5] && !scene) begin
                isec_tog_reg <= ~isec_tog_reg;
            end
            if (rise[5] && !scene && mode_on) begin
                isec_tmr_reg <= 1'b1;
                isec_cnt_reg <= 28'h0000000;
            end else if (!mode_on) begin
                isec_tmr_reg <= 1'b0;
            end else if (isec_tmr_reg) begin
                // Counted in clock cycles, no separate timebase
                if (isec_cnt_reg >= ISEC_CYC - 28'h0000001) begin
                    isec_tmr_reg <= 1'b0;
                end else begin
                    isec_cnt_reg <= isec_cnt_reg + 28'h0000001;
                end
            end
        end
    end

    // Low power lockout after a mode change
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            state_d_reg <= 3'h0;
            lp_block_reg <= 1'b0;
        end else if (clk_en_i) begin
            state_d_reg <= state_now;
            // Change wins over re-arm in the same cycle
            if (mode_chg) begin
                lp_block_reg <= 1'b1;
            end else if (!lp_l) begin
                lp_block_reg <= 1'b0;
            end
        end
    end

    // Register writes and button stepping share the pattern store
    integer i;
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            cutpol_reg <= `LBC_CTRL_RST;
            for (i = 0; i < 4; i = i + 1) begin
                pat_reg[i] <= `LBC_PAT_RST;
            end
        end else if (clk_en_i) begin
            if (wr_i) begin
                case (addr_i)
                    `LBC_OFS_CTRL: cutpol_reg <=
                        wdata_i[`LBC_CTRL_CUTPOL_BIT];
                    `LBC_OFS_PAT1: pat_reg[1] <= wdata_i[3:0];
                    `LBC_OFS_PAT2: pat_reg[2] <= wdata_i[3:0];
                    `LBC_OFS_PAT3: pat_reg[3] <= wdata_i[3:0];
                    `LBC_OFS_PATI: pat_reg[0] <= wdata_i[3:0];
                    default: ;
                endcase
            end else if (do_step) begin
                // Index wraps at either end of the range
                if (step_back) begin
                    pat_reg[sel] <= pat_reg[sel] - 4'h1;
                end else begin
                    pat_reg[sel] <= pat_reg[sel] + 4'h1;
                end
            end
        end
    end

    // Read port, data one cycle after the strobe, zero elsewhere
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            rdata_o <= 32'h00000000;
        end else if (clk_en_i) begin
            rdata_o <= 32'h00000000;
            if (rd_i) begin
                case (addr_i)
                    `LBC_OFS_CTRL: rdata_o[`LBC_CTRL_CUTPOL_BIT] <=
                        cutpol_reg;
                    `LBC_OFS_PAT1: rdata_o[3:0] <= pat_reg[1];
                    `LBC_OFS_PAT2: rdata_o[3:0] <= pat_reg[2];
                    `LBC_OFS_PAT3: rdata_o[3:0] <= pat_reg[3];
                    `LBC_OFS_PATI: rdata_o[3:0] <= pat_reg[0];
                    `LBC_OFS_STAT: begin
                        rdata_o[`LBC_STAT_MODE_LSB+1:`LBC_STAT_MODE_LSB]
                            <= mode_o;
                        rdata_o[`LBC_STAT_ISEC_BIT] <= isec_o;
                        rdata_o[`LBC_STAT_LP_BIT] <= low_power_o;
                        rdata_o[`LBC_STAT_PROG_BIT] <= program_o;
                        rdata_o[`LBC_STAT_DWINT_BIT] <= dw_internal_o;
                        rdata_o[`LBC_STAT_CUTPOL_BIT] <= cutpol_reg;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Registered requests toward the light bar
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            mode_o <= 2'h0;
            pattern_o <= 4'h0;
            isec_o <= 1'b0;
            front_en_o <= 1'b0;
            rear_en_o <= 1'b0;
            steady_o <= 1'b0;
            alley_l_o <= 1'b0;
            alley_r_o <= 1'b0;
            alley_flash_o <= 1'b0;
            td_flash_o <= 1'b0;
            td_steady_o <= 1'b0;
            low_power_o <= 1'b0;
            autodim_ovr_o <= 1'b0;
            scene_l_o <= 1'b0;
            scene_r_o <= 1'b0;
            test_o <= 1'b0;
            dw_internal_o <= 1'b0;
            dw_ext_o <= 8'h00;
            program_o <= 1'b0;
        end else if (clk_en_i) begin
            mode_o <= mode;
            pattern_o <= mode_on ? pat_reg[sel] : 4'h0;
            isec_o <= isec_act;
            front_en_o <= mode_on & ~cut_f;
            rear_en_o <= mode_on & ~cut_r;
            steady_o <= steady_l & mode_on;
            alley_l_o <= al_l;
            alley_r_o <= ar_l;
            alley_flash_o <= ftd_act;
            // Takedown flash gone under front cutoff or steady takedown
            td_flash_o <= ftd_act & ~cut_f & ~td_l;
            td_steady_o <= td_l;
            // Change cycle itself gated so no dim leaks into the new mode
            low_power_o <= lp_l & lp_ok & ~lp_block_reg & ~mode_chg;
            autodim_ovr_o <= fall[12];
            scene_l_o <= scene & isec_l;
            scene_r_o <= scene & test_l;
            test_o <= ~scene & test_l;
            dw_internal_o <= dw_int;
            dw_ext_o <= dw_int ? 8'h00 : dw_s2_reg;
            program_o <= prog;
        end
    end
endmodule

/* verif/lbc_input_logic_assertions.sv */
// Port-level assertions for the light-bar input decision logic
`timescale 1ns/1ps
module lbc_input_logic_assertions (
    input wire core_clk_i,
    input wire reset_i,
    input wire [1:0] mode_o,
    input wire [3:0] pattern_o,
    input wire isec_o,
    input wire steady_o,
    input wire alley_flash_o,
    input wire td_flash_o,
    input wire td_steady_o,
    input wire low_power_o,
    input wire autodim_ovr_o,
    input wire dw_internal_o,
    input wire [7:0] dw_ext_o
);
    // One clock domain, reset masks everything
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    // A step of the winning mode
    sequence mode_move;
        $changed(mode_o);
    endsequence
    // Override pulse seen once
    sequence ovr_seen;
        autodim_ovr_o ##1 1'b1;
    endsequence
    chk_isec_needs_mode: assert property (
        isec_o |-> mode_o != 2'h0)
        else $error("intersection without a mode");
    chk_lp_only_low: assert property (
        low_power_o |-> (mode_o == 2'h1 || mode_o == 2'h2) && !isec_o)
        else $error("dimming outside mode one or two");
    chk_lp_cancel: assert property (
        mode_move |-> !low_power_o)
        else $error("dimming kept across a mode change");
    chk_flash_needs_mode: assert property (
        (alley_flash_o || td_flash_o) |-> mode_o != 2'h0)
        else $error("flash without a mode");
    chk_td_over_flash: assert property (
        td_steady_o |-> !td_flash_o)
        else $error("takedown flash beside steady takedown");
    chk_steady_mode: assert property (
        steady_o |-> mode_o != 2'h0)
        else $error("steady burn without a mode");
    chk_pat_idle: assert property (
        mode_o == 2'h0 |-> pattern_o == 4'h0)
        else $error("pattern sent with no mode");
    chk_ovr_pulse: assert property (
        ovr_seen |-> !autodim_ovr_o)
        else $error("override pulse longer than one cycle");
    chk_dw_gate: assert property (
        dw_internal_o |-> dw_ext_o == 8'h00)
        else $error("external heads passed in internal control");
endmodule

/* verif/lbc_bar_model.sv */
// Behavioural light-bar controller seen across the serial cable
`timescale 1ns/1ps
module lbc_bar_model (
    input wire core_clk_i,
    input wire reset_i,
    input wire low_power_i,
    input wire autodim_ovr_i,
    output reg [6:0] bright_pct_o,
    output reg [7:0] ovr_count_o
);
    // Counts autodim overrides; the bench compares the count
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            ovr_count_o <= 8'h00;
        end else if (autodim_ovr_i) begin
            ovr_count_o <= ovr_count_o + 8'h01;
        end
    end
    // Quarter brightness while dimming is requested
    always @* begin
        bright_pct_o = low_power_i ? 7'h19 : 7'h64;
    end
endmodule

/* verif/tb.sv */
// Self-checking bench for the light-bar input decision logic
`timescale 1ns/1ps
`include "lbc_map.vh"
module tb;
    reg core_clk_i = 1'b0;
    reg reset_i = 1'b1;
    reg [12:0] lead = 13'h0000; // Leads: see bit names below
    reg [7:0] dw_ext_i = 8'hA5;
    reg [7:0] sw = 8'h00; // Switch bank, only changed in reset
    reg btn = 1'b0;
    reg [7:0] addr_i = 8'h00;
    reg [31:0] wdata_i = 32'h0;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    reg [31:0] v;
    integer err_total = 0;
    integer checks = 0;
    integer cyc = 0;
    wire [31:0] rdata_o;
    wire [1:0] mode_o;
    wire [3:0] pattern_o;
    wire [7:0] dw_ext_o, ovr_n;
    wire [6:0] pct;
    wire isec_o, front_en_o, rear_en_o, steady_o, alley_l_o, alley_r_o;
    wire alley_flash_o, td_flash_o, td_steady_o, low_power_o, autodim_o;
    wire scene_l_o, scene_r_o, test_o, dw_internal_o, program_o;
    // Lead bit positions
    localparam [12:0] M1 = 13'h1, M2 = 13'h2, M3 = 13'h4, ST = 13'h8;
    localparam [12:0] IS = 13'h10, FL = 13'h20, AL = 13'h40, AR = 13'h80;
    localparam [12:0] TD = 13'h100, FC = 13'h200, RC = 13'h400;
    localparam [12:0] LP = 13'h800, TS = 13'h1000;
    always #25 core_clk_i = ~core_clk_i;
    // Short debounce and timeout keep the run brief
    lbc_input_logic #(.DEB_CYC(20'h4), .ISEC_CYC(28'h32)) dut_u (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .clk_en_i(1'b1),
        .mode1_i(lead[0]), .mode2_i(lead[1]), .mode3_i(lead[2]),
        .steady_i(lead[3]), .isec_i(lead[4]), .flash_td_i(lead[5]),
        .alley_l_i(lead[6]), .alley_r_i(lead[7]), .takedown_i(lead[8]),
        .front_cut_i(lead[9]), .rear_cut_i(lead[10]),
        .low_power_i(lead[11]), .test_i(lead[12]), .dw_ext_i(dw_ext_i),
        .config_switch_bank_i(sw), .pattern_step_button_i(btn),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .mode_o(mode_o), .pattern_o(pattern_o),
        .isec_o(isec_o), .front_en_o(front_en_o), .rear_en_o(rear_en_o),
        .steady_o(steady_o), .alley_l_o(alley_l_o), .alley_r_o(alley_r_o),
        .alley_flash_o(alley_flash_o), .td_flash_o(td_flash_o),
        .td_steady_o(td_steady_o), .low_power_o(low_power_o),
        .autodim_ovr_o(autodim_o), .scene_l_o(scene_l_o),
        .scene_r_o(scene_r_o), .test_o(test_o),
        .dw_internal_o(dw_internal_o), .dw_ext_o(dw_ext_o),
        .program_o(program_o));
    lbc_bar_model bar_u (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .low_power_i(low_power_o), .autodim_ovr_i(autodim_o),
        .bright_pct_o(pct), .ovr_count_o(ovr_n));
    // Compare one result and count it
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // Drive leads, then wait out sync, debounce and output register
    task setl(input [12:0] l);
        begin
            @(posedge core_clk_i) lead <= l;
            repeat (12) @(posedge core_clk_i);
            #1;
        end
    endtask
    // One-cycle register write
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge core_clk_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
            @(posedge core_clk_i) wr_i <= 1'b0;
        end
    endtask
    // One-cycle read; data stand only in the following cycle
    task rd(input [7:0] a, output [31:0] d);
        begin
            @(posedge core_clk_i) {rd_i, addr_i} <= {1'b1, a};
            @(posedge core_clk_i) rd_i <= 1'b0;
            #1 d = rdata_o;
        end
    endtask
    // Switches move only while the block is held in reset
    task do_reset(input [7:0] s);
        begin
            @(posedge core_clk_i) {reset_i, sw, lead} <= {1'b1, s, 13'h0};
            repeat (5) @(posedge core_clk_i);
            reset_i <= 1'b0;
            repeat (10) @(posedge core_clk_i);
        end
    endtask
    // Priority, stored patterns, steady burn and register reads
    task t_modes;
        begin
            wr(`LBC_OFS_PAT1, 32'h3);
            wr(`LBC_OFS_PAT2, 32'h5);
            wr(`LBC_OFS_PAT3, 32'h9);
            setl(M1 | ST);
            chk({mode_o, pattern_o, steady_o}, 7'h27);
            setl(M1 | M2);
            chk({mode_o, pattern_o}, 6'h25);
            setl(M1 | M2 | M3);
            chk({mode_o, pattern_o}, 6'h39);
            rd(`LBC_OFS_STAT, v);
            chk(v[1:0], 2'h3);
            rd(`LBC_OFS_PAT2, v);
            chk(v, 32'h5);
            rd(8'h18, v);
            chk(v, 32'h0);
            chk({program_o, dw_internal_o}, 2'h0);
            setl(ST);
            chk({mode_o, pattern_o, steady_o}, 7'h00);
            $display("test modes done");
        end
    endtask
    // Cutoffs under both polarities
    task t_cut;
        begin
            setl(M1 | FC);
            chk({front_en_o, rear_en_o}, 2'h1);
            setl(M1 | RC);
            chk({front_en_o, rear_en_o}, 2'h2);
            wr(`LBC_OFS_CTRL, 32'h1);
            setl(M1);
            chk({front_en_o, rear_en_o}, 2'h0);
            setl(M1 | FC | RC);
            chk({front_en_o, rear_en_o}, 2'h3);
            wr(`LBC_OFS_CTRL, 32'h0);
            $display("test cutoff done");
        end
    endtask
    // Flash, takedown and alley order of precedence
    task t_alley;
        begin
            setl(M1 | FL);
            chk({alley_flash_o, td_flash_o, td_steady_o}, 3'h6);
            setl(M1 | FL | FC);
            chk({alley_flash_o, td_flash_o, td_steady_o}, 3'h4);
            setl(M1 | FL | FC | TD);
            chk({td_flash_o, td_steady_o}, 2'h1);
            setl(FL | AL);
            chk({alley_l_o, alley_r_o, alley_flash_o}, 3'h4);
            setl(FL | AR);
            chk({alley_l_o, alley_r_o, td_flash_o}, 3'h2);
            $display("test alley done");
        end
    endtask
    // Low power, its cancel and re-arm, and autodim override
    task t_lp;
        begin
            setl(M1);
            setl(M1 | LP);
            chk({low_power_o, pct}, 8'h99);
            setl(M1);
            chk(ovr_n, 8'h01);
            chk({low_power_o, pct}, 8'h64);
            setl(M1 | LP);
            setl(M1 | M2 | LP);
            chk({mode_o, low_power_o}, 3'h4);
            setl(M1 | M2);
            setl(M1 | M2 | LP);
            chk(low_power_o, 1'b1);
            setl(M1 | M2 | M3 | LP);
            chk(low_power_o, 1'b0);
            setl(M1 | M2 | LP);
            chk(low_power_o, 1'b0);
            $display("test low power done");
        end
    endtask
    // Level, toggle and timed intersection
    task t_isec;
        begin
            setl(IS);
            chk(isec_o, 1'b0);
            wr(`LBC_OFS_PATI, 32'h7);
            setl(M1 | IS);
            chk({isec_o, pattern_o}, 5'h17);
            setl(M1);
            chk({mode_o, isec_o, pattern_o}, 7'h23);
            do_reset(8'h40);
            setl(M1 | IS);
            setl(M1);
            chk(isec_o, 1'b1);
            setl(M1 | IS);
            chk(isec_o, 1'b0);
            do_reset(8'h80);
            setl(M1 | IS);
            chk(isec_o, 1'b1);
            // Second press while timing restarts the count
            setl(M1);
            setl(M1 | IS);
            repeat (30) @(posedge core_clk_i);
            #1 chk(isec_o, 1'b1);
            repeat (30) @(posedge core_clk_i);
            #1 chk(isec_o, 1'b0);
            $display("test intersection done");
        end
    endtask
    // Scene, directional control and pattern stepping switches
    task t_sw(input [7:0] s, input [3:0] pat);
        begin
            do_reset(s);
            setl(M1 | IS | TS);
            v = s[2] ? 32'hC : 32'h3; // Scene on drops both originals
            chk({scene_l_o, scene_r_o, isec_o, test_o}, v);
            chk({dw_internal_o, dw_ext_o}, s[3] ? 9'h100 : 9'hA5);
            chk(program_o, 1'b1);
            setl(M1); // Intersection off so the mode index steps
            @(posedge core_clk_i) btn <= 1'b1;
            setl(M1);
            @(posedge core_clk_i) btn <= 1'b0;
            setl(M1);
            chk(pattern_o, pat);
            $display("test switches done");
        end
    endtask
    // Verdict and end of run
    task wrap_up;
        begin
            $display("checks=%0d err_total=%0d", checks, err_total);
            if (err_total == 0 && checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // Hang guard
    always @(posedge core_clk_i) begin
        cyc = cyc + 1;
        if (cyc == 6000) begin
            err_total = err_total + 1;
            wrap_up;
        end
    end
    initial begin
        do_reset(8'h00);
        t_modes;
        t_cut;
        t_alley;
        t_lp;
        t_isec;
        t_sw(8'h24, 4'h1);
        t_sw(8'h38, 4'hF);
        wrap_up;
    end
endmodule
bind lbc_input_logic lbc_input_logic_assertions chk_u (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .mode_o(mode_o),
    .pattern_o(pattern_o), .isec_o(isec_o), .steady_o(steady_o),
    .alley_flash_o(alley_flash_o), .td_flash_o(td_flash_o),
    .td_steady_o(td_steady_o), .low_power_o(low_power_o),
    .autodim_ovr_o(autodim_ovr_o), .dw_internal_o(dw_internal_o),
    .dw_ext_o(dw_ext_o));
